// *** design/srx_exec_core.sv ***
// Executor for stack, return, no-operation and one-bit shift operations
`timescale 1ns/10ps
// Functional notes
// - No-operation changes nothing, waits one cycle
// - Pop: read top, step pointer, write destination
// - Byte pop to register clears high byte
// - Pop always steps pointer by two
// - Push: pointer minus two, then write word
// - Byte push writes low byte lane only
// - Stack ops and subroutine exit keep all flags
// - Subroutine exit loads pc, clears top four
// - Interrupt return pops status, then pc low
// - Interrupt return restores flags and mode bits
// - Left shift: msb to carry, zero in
// - Word left shift equals operand added to itself
// - Word left overflow for 4000 to bfff
// - Byte left overflow for 40 to bf
// - Left shifts set carry, negative and zero
// - Rotate left inserts old carry at bit zero
// - Right shift keeps sign, lsb to carry
// - Right shift negative equals result msb
// - Right shift sets zero, carry; clears overflow
module srx_exec_core (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire srx_pkg::srx_op_e op_code,
  input wire logic op_byte,
  input wire logic dst_is_reg,
  input wire logic [15:0] operand,
  input wire logic [15:0] mem_rdata,
  input wire logic sp_set,
  input wire logic [19:0] sp_value,
  input wire logic sr_set,
  input wire logic [15:0] sr_value,
  output logic busy_q,
  output logic done_q,
  output logic mem_rd_q,
  output logic mem_wr_q,
  output logic [19:0] mem_addr_q,
  output logic [15:0] mem_wdata_q,
  output logic [1:0] mem_be_q,
  output logic dst_wr_q,
  output logic [15:0] dst_wdata_q,
  output logic [1:0] dst_be_q,
  output logic [19:0] sp_q,
  output logic [19:0] pc_q,
  output logic flag_c_q,
  output logic flag_z_q,
  output logic flag_n_q,
  output logic flag_v_q,
  output logic global_interrupt_enable_q,
  output logic processor_halt_q,
  output logic oscillator_disable_q
);
  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n_s;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s <= rst_meta_q;
    end
  end

  // ==========================================================
  // Decoding helpers
  function automatic logic is_shift(input srx_pkg::srx_op_e op);
    is_shift = (op == srx_pkg::OP_SHIFT_LEFT_ARITH) ||
      (op == srx_pkg::OP_ROTATE_LEFT_CARRY) ||
      (op == srx_pkg::OP_SHIFT_RIGHT_ARITH);
  endfunction

  function automatic logic is_left(input srx_pkg::srx_op_e op);
    is_left = (op == srx_pkg::OP_SHIFT_LEFT_ARITH) ||
      (op == srx_pkg::OP_ROTATE_LEFT_CARRY);
  endfunction

  // Status word to internal flag vector
  function automatic logic [6:0] unpack_sr(input logic [15:0] w);
    unpack_sr = 7'h00;
    unpack_sr[srx_pkg::FLG_C] = w[srx_pkg::SR_C];
    unpack_sr[srx_pkg::FLG_Z] = w[srx_pkg::SR_Z];
    unpack_sr[srx_pkg::FLG_N] = w[srx_pkg::SR_N];
    unpack_sr[srx_pkg::FLG_V] = w[srx_pkg::SR_V];
    unpack_sr[srx_pkg::FLG_GIE] = w[srx_pkg::SR_GIE];
    unpack_sr[srx_pkg::FLG_HALT] = w[srx_pkg::SR_HALT];
    unpack_sr[srx_pkg::FLG_OSC] = w[srx_pkg::SR_OSC];
  endfunction

  // ==========================================================
  // State and latched request
  srx_pkg::srx_state_e state_q;
  srx_pkg::srx_state_e state_d;
  srx_pkg::srx_op_e op_q;
  logic byte_q;
  logic reg_dst_q;
  logic [15:0] opnd_q;
  logic phase2_q;
  logic phase2_d;
  logic [19:0] sp_d;
  logic [19:0] pc_d;
  logic [6:0] flags_q;
  logic [6:0] flags_d;
  logic [19:0] mem_addr_d;
  logic mem_rd_d;
  logic mem_wr_d;
  logic [15:0] mem_wdata_d;
  logic [1:0] mem_be_d;
  logic dst_wr_d;
  logic [15:0] dst_wdata_d;
  logic [1:0] dst_be_d;
  logic done_d;

  wire accept = op_valid && (state_q == srx_pkg::ST_IDLE);
  wire [1:0] size_be = op_byte ? srx_pkg::BE_LOW : srx_pkg::BE_WORD;
  wire [15:0] push_data = op_byte ?
    {srx_pkg::HIGH_BYTE_CLEAR, operand[7:0]} : operand;
  // Register targets take a whole word so the high byte really clears
  wire [1:0] pop_be = (byte_q && !reg_dst_q) ?
    srx_pkg::BE_LOW : srx_pkg::BE_WORD;
  wire [15:0] pop_data = byte_q ?
    {srx_pkg::HIGH_BYTE_CLEAR, mem_rdata[7:0]} : mem_rdata;
  wire [1:0] shift_be = (op_byte && !dst_is_reg) ?
    srx_pkg::BE_LOW : srx_pkg::BE_WORD;

  assign flags_q = {oscillator_disable_q, processor_halt_q,
    global_interrupt_enable_q, flag_v_q, flag_n_q, flag_z_q, flag_c_q};

  // ==========================================================
  // Datapath helpers
  logic [19:0] sp_inc;
  logic [19:0] sp_dec;
  logic [15:0] sh_result;
  logic sh_n;
  logic sh_z;
  logic sh_c;
  logic sh_v;

  srx_stack_adj u_stack_adj (
    .sp(sp_q),
    .sp_inc(sp_inc),
    .sp_dec(sp_dec)
  );

  srx_shifter u_shifter (
    .opnd(operand),
    .is_byte(op_byte),
    .is_rlc(op_code == srx_pkg::OP_ROTATE_LEFT_CARRY),
    .is_rra(op_code == srx_pkg::OP_SHIFT_RIGHT_ARITH),
    .carry_in(flag_c_q),
    .result(sh_result),
    .res_n(sh_n),
    .res_z(sh_z),
    .res_c(sh_c),
    .res_v(sh_v)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    phase2_d = phase2_q;
    sp_d = sp_q;
    pc_d = pc_q;
    flags_d = flags_q;
    mem_addr_d = mem_addr_q;
    mem_rd_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_wdata_d = mem_wdata_q;
    mem_be_d = mem_be_q;
    dst_wr_d = 1'b0;
    dst_wdata_d = dst_wdata_q;
    dst_be_d = dst_be_q;
    done_d = 1'b0;
    case (state_q)
      srx_pkg::ST_IDLE: begin
        if (accept) begin
          done_d = 1'b1;
          if (op_code == srx_pkg::OP_PUSH) begin
            sp_d = sp_dec;
            mem_addr_d = sp_dec;
            mem_wr_d = 1'b1;
            mem_wdata_d = push_data;
            mem_be_d = size_be;
          end else if (is_shift(op_code)) begin
            dst_wr_d = 1'b1;
            dst_wdata_d = sh_result;
            dst_be_d = shift_be;
            flags_d[srx_pkg::FLG_C] = sh_c;
            flags_d[srx_pkg::FLG_Z] = sh_z;
            flags_d[srx_pkg::FLG_N] = sh_n;
            flags_d[srx_pkg::FLG_V] = sh_v;
          end else if (op_code != srx_pkg::OP_NO_OPERATION) begin
            done_d = 1'b0;
            mem_addr_d = sp_q;
            mem_rd_d = 1'b1;
            phase2_d = 1'b0;
            state_d = srx_pkg::ST_RD_WAIT;
          end
        end else begin
          if (sp_set) begin
            sp_d = sp_value;
          end
          if (sr_set) begin
            flags_d = unpack_sr(sr_value);
          end
        end
      end
      srx_pkg::ST_RD_WAIT: begin
        state_d = srx_pkg::ST_RD_CAP;
      end
      srx_pkg::ST_RD_CAP: begin
        sp_d = sp_inc;
        state_d = srx_pkg::ST_IDLE;
        done_d = 1'b1;
        case (op_q)
          srx_pkg::OP_POP: begin
            dst_wr_d = 1'b1;
            dst_wdata_d = pop_data;
            dst_be_d = pop_be;
          end
          srx_pkg::OP_SUBROUTINE_EXIT: begin
            pc_d = {srx_pkg::PC_HI_CLEAR, mem_rdata};
          end
          srx_pkg::OP_INTERRUPT_RETURN: begin
            if (!phase2_q) begin
              flags_d = unpack_sr(mem_rdata);
              pc_d[19:16] = mem_rdata[srx_pkg::SR_PC_HI_LSB +: 4];
              mem_addr_d = sp_inc;
              mem_rd_d = 1'b1;
              phase2_d = 1'b1;
              state_d = srx_pkg::ST_RD_WAIT;
              done_d = 1'b0;
            end else begin
              pc_d[15:0] = mem_rdata;
            end
          end
          default: begin
          end
        endcase
      end
      default: begin
        state_d = srx_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q <= srx_pkg::ST_IDLE;
      phase2_q <= 1'b0;
      op_q <= srx_pkg::OP_NO_OPERATION;
      byte_q <= 1'b0;
      reg_dst_q <= 1'b0;
      opnd_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase2_q <= phase2_d;
      if (accept) begin
        op_q <= op_code;
        byte_q <= op_byte;
        reg_dst_q <= dst_is_reg;
        opnd_q <= operand;
      end
      busy_q <= (state_d != srx_pkg::ST_IDLE);
      done_q <= done_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sp_q <= srx_pkg::SP_RESET;
      pc_q <= srx_pkg::PC_RESET;
      {oscillator_disable_q, processor_halt_q, global_interrupt_enable_q,
        flag_v_q, flag_n_q, flag_z_q, flag_c_q} <= srx_pkg::FLAGS_RESET;
    end else begin
      sp_q <= sp_d;
      pc_q <= pc_d;
      {oscillator_disable_q, processor_halt_q, global_interrupt_enable_q,
        flag_v_q, flag_n_q, flag_z_q, flag_c_q} <= flags_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      mem_addr_q <= 20'h00000;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= 16'h0000;
      mem_be_q <= srx_pkg::BE_WORD;
      dst_wr_q <= 1'b0;
      dst_wdata_q <= 16'h0000;
      dst_be_q <= srx_pkg::BE_WORD;
    end else begin
      mem_addr_q <= mem_addr_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      mem_wdata_q <= mem_wdata_d;
      mem_be_q <= mem_be_d;
      dst_wr_q <= dst_wr_d;
      dst_wdata_q <= dst_wdata_d;
      dst_be_q <= dst_be_d;
    end
  end

  // ==========================================================
  // Checks
  wire done_shift = done_q && is_shift(op_q);

  chk_nop_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    accept && op_code == srx_pkg::OP_NO_OPERATION |=> done_q &&
    $stable(sp_q) && $stable(pc_q) && $stable(flags_q) &&
    !dst_wr_q && !mem_wr_q)
    else $error("no-operation changed state");
  chk_pop_sp_step: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    accept && op_code == srx_pkg::OP_POP |-> ##3
    dst_wr_q && sp_q == $past(sp_q, 3) + srx_pkg::SP_STEP)
    else $error("pop did not step pointer by two");
  chk_pop_byte_reg: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    dst_wr_q && op_q == srx_pkg::OP_POP && byte_q && reg_dst_q |->
    dst_wdata_q[15:8] == 8'h00 && dst_be_q == srx_pkg::BE_WORD)
    else $error("byte pop left high byte");
  chk_push_order: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    accept && op_code == srx_pkg::OP_PUSH |=> mem_wr_q &&
    sp_q == $past(sp_q) - srx_pkg::SP_STEP && mem_addr_q == sp_q)
    else $error("push address wrong");
  chk_push_byte_lane: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    mem_wr_q && byte_q |-> mem_be_q == srx_pkg::BE_LOW)
    else $error("byte push touched high lane");
  // Judged at the closing pulse: a following load or shift may move flags
  chk_flags_kept: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_q && !is_shift(op_q) &&
    op_q != srx_pkg::OP_INTERRUPT_RETURN |-> $stable(flags_q))
    else $error("flags moved on stack operation");
  chk_ret_pc_high: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_q && op_q == srx_pkg::OP_SUBROUTINE_EXIT |->
    pc_q[19:16] == 4'h0)
    else $error("subroutine exit kept pc high bits");
  chk_interrupt_return_sp: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    accept && op_code == srx_pkg::OP_INTERRUPT_RETURN |-> ##5 done_q &&
    sp_q == $past(sp_q, 5) + srx_pkg::SP_STEP + srx_pkg::SP_STEP)
    else $error("interrupt return pointer wrong");
  chk_interrupt_return_flags: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    state_q == srx_pkg::ST_RD_CAP && op_q == srx_pkg::OP_INTERRUPT_RETURN &&
    !phase2_q |=> flags_q == unpack_sr($past(mem_rdata)))
    else $error("status not restored");
  chk_rla_double: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_shift && op_q == srx_pkg::OP_SHIFT_LEFT_ARITH && !byte_q |->
    dst_wdata_q == opnd_q + opnd_q)
    else $error("left shift is not a doubling");
  chk_left_ovf: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_shift && is_left(op_q) |-> flag_v_q == (byte_q ?
    (opnd_q[7:0] >= 8'h40 && opnd_q[7:0] < 8'hc0) :
    (opnd_q >= 16'h4000 && opnd_q < 16'hc000)))
    else $error("left shift overflow wrong");
  chk_left_carry: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_shift && is_left(op_q) |-> flag_z_q == (dst_wdata_q == 16'h0000) &&
    flag_c_q == (byte_q ? opnd_q[7] : opnd_q[15]))
    else $error("left shift carry or zero wrong");
  chk_rlc_carry_in: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_shift && op_q == srx_pkg::OP_ROTATE_LEFT_CARRY |->
    dst_wdata_q[0] == $past(flag_c_q))
    else $error("rotate lost old carry");
  chk_rra_sign: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_shift && op_q == srx_pkg::OP_SHIFT_RIGHT_ARITH && !byte_q |->
    dst_wdata_q[15] == opnd_q[15] && dst_wdata_q[14] == opnd_q[15] &&
    flag_c_q == opnd_q[0] && flag_n_q == dst_wdata_q[15] &&
    !flag_v_q)
    else $error("right shift result wrong");
  chk_byte_shift_high: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
    done_shift && byte_q |-> dst_wdata_q[15:8] == 8'h00)
    else $error("byte shift touched high byte");
endmodule

// *** design/srx_pkg.sv ***
// Shared constants and types for the stack, return and shift executor
package srx_pkg;

  // ==========================================================
  // Operation and state encodings
  typedef enum logic [2:0] {
    OP_NO_OPERATION,
    OP_POP,
    OP_PUSH,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_RETURN,
    OP_SHIFT_LEFT_ARITH,
    OP_ROTATE_LEFT_CARRY,
    OP_SHIFT_RIGHT_ARITH
  } srx_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_RD_CAP
  } srx_state_e;

  // ==========================================================
  // Widths, steps and reset values
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [19:0] SP_RESET = 20'h00000;
  localparam logic [19:0] PC_RESET = 20'h00000;
  localparam logic [19:0] SP_STEP = 20'h00002;
  localparam logic [3:0] PC_HI_CLEAR = 4'h0;
  localparam logic [7:0] HIGH_BYTE_CLEAR = 8'h00;
  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // ==========================================================
  // Status word layout in memory and on the set port
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_GIE = 3;
  localparam int SR_HALT = 4;
  localparam int SR_OSC = 5;
  localparam int SR_V = 8;
  localparam int SR_PC_HI_LSB = 12;

  // Positions inside the internal flag vector
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_GIE = 4;
  localparam int FLG_HALT = 5;
  localparam int FLG_OSC = 6;

  // ==========================================================
  // Overflow windows of the left shifts
  localparam logic [15:0] OVF_WORD_LO = 16'h4000;
  localparam logic [15:0] OVF_WORD_HI = 16'hc000;
  localparam logic [7:0] OVF_BYTE_LO = 8'h40;
  localparam logic [7:0] OVF_BYTE_HI = 8'hc0;

endpackage

// *** design/srx_stack_adj.sv ***
// Stack pointer step adders
`timescale 1ns/10ps
module srx_stack_adj (
  input wire logic [19:0] sp,
  output logic [19:0] sp_inc,
  output logic [19:0] sp_dec
);
  // The step is always one word, whatever the operand size
  assign sp_inc = sp + srx_pkg::SP_STEP;
  assign sp_dec = sp - srx_pkg::SP_STEP;
endmodule

// *** design/srx_shifter.sv ***
// One-bit shift and rotate unit with flag generation
`timescale 1ns/10ps
module srx_shifter (
  input wire logic [15:0] opnd,
  input wire logic is_byte,
  input wire logic is_rlc,
  input wire logic is_rra,
  input wire logic carry_in,
  output logic [15:0] result,
  output logic res_n,
  output logic res_z,
  output logic res_c,
  output logic res_v
);
  // ==========================================================
  // Operand views
  logic [15:0] w_in;
  logic [15:0] left_raw;
  logic [15:0] left_res;
  logic [15:0] right_res;
  logic msb;
  logic ovf_word;
  logic ovf_byte;

  assign w_in = is_byte ? {srx_pkg::HIGH_BYTE_CLEAR, opnd[7:0]} : opnd;
  assign msb = is_byte ? opnd[7] : opnd[15];

  // ==========================================================
  // Left forms: zero or old carry enters bit 0
  assign left_raw = {w_in[14:0], is_rlc & carry_in};
  assign left_res = is_byte ?
    {srx_pkg::HIGH_BYTE_CLEAR, left_raw[7:0]} : left_raw;

  // Right form keeps the sign bit and copies it one place down
  assign right_res = is_byte ?
    {srx_pkg::HIGH_BYTE_CLEAR, opnd[7], opnd[7:1]} :
    {opnd[15], opnd[15:1]};

  assign result = is_rra ? right_res : left_res;

  // ==========================================================
  // Flags
  assign ovf_word = (opnd >= srx_pkg::OVF_WORD_LO) &&
    (opnd < srx_pkg::OVF_WORD_HI);
  assign ovf_byte = (opnd[7:0] >= srx_pkg::OVF_BYTE_LO) &&
    (opnd[7:0] < srx_pkg::OVF_BYTE_HI);
  assign res_c = is_rra ? opnd[0] : msb;
  assign res_n = is_byte ? result[7] : result[15];
  assign res_z = (result == 16'h0000);
  assign res_v = is_rra ? 1'b0 : (is_byte ? ovf_byte : ovf_word);
endmodule

// *** tb/tb_stack_return_shift_exec.sv ***
// Self-checking testbench for the stack, return and shift executor
`timescale 1ns/10ps
module tb_stack_return_shift_exec;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  srx_pkg::srx_op_e op_code = srx_pkg::OP_NO_OPERATION;
  logic op_byte = 1'b0;
  logic dst_is_reg = 1'b0;
  logic [15:0] operand = 16'h0000;
  logic [15:0] mem_rdata = 16'h0000;
  logic sp_set = 1'b0;
  logic [19:0] sp_value = 20'h00000;
  logic sr_set = 1'b0;
  logic [15:0] sr_value = 16'h0000;
  logic busy_q, done_q, mem_rd_q, mem_wr_q, dst_wr_q;
  logic [19:0] mem_addr_q, sp_q, pc_q;
  logic [15:0] mem_wdata_q, dst_wdata_q;
  logic [1:0] mem_be_q, dst_be_q;
  logic flag_c_q, flag_z_q, flag_n_q, flag_v_q;
  logic global_interrupt_enable_q, processor_halt_q, oscillator_disable_q;
  int num_errors = 0;
  int n_checks = 0;
  int lat;
  logic saw_wr, saw_dst;
  logic [15:0] c_dwd, c_mwd;
  logic [1:0] c_dbe, c_mbe;
  logic [19:0] c_maddr, esp, epc;
  logic [6:0] efl;
  logic [15:0] tv [10] = '{16'h4000, 16'h3fff, 16'hbfff, 16'hc000, 16'h8000,
                           16'h0001, 16'ha5c0, 16'h7f3f, 16'h00bf, 16'h0040};

  always #25 ref_clk = ~ref_clk;

  srx_exec_core DUT (.ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .op_byte(op_byte), .dst_is_reg(dst_is_reg),
    .operand(operand), .mem_rdata(mem_rdata), .sp_set(sp_set),
    .sp_value(sp_value), .sr_set(sr_set), .sr_value(sr_value),
    .busy_q(busy_q), .done_q(done_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_be_q(mem_be_q), .dst_wr_q(dst_wr_q), .dst_wdata_q(dst_wdata_q),
    .dst_be_q(dst_be_q), .sp_q(sp_q), .pc_q(pc_q), .flag_c_q(flag_c_q),
    .flag_z_q(flag_z_q), .flag_n_q(flag_n_q), .flag_v_q(flag_v_q),
    .global_interrupt_enable_q(global_interrupt_enable_q),
    .processor_halt_q(processor_halt_q),
    .oscillator_disable_q(oscillator_disable_q));

  // ==========================================================
  // Comparison and closing
  task automatic check(input logic [19:0] seen, input logic [19:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_state(input string w);
    check(sp_q, esp, {w, " sp"});
    check(pc_q, epc, {w, " pc"});
    check(20'({oscillator_disable_q, processor_halt_q,
      global_interrupt_enable_q, flag_v_q, flag_n_q, flag_z_q, flag_c_q}),
      20'(efl), {w, " flags"});
  endtask

  // Flag vector order follows the package positions C Z N V GLOBAL_INTERRUPT_ENABLE HALT OSC
  task automatic load(input logic [19:0] sp, input logic [15:0] sr);
    @(negedge ref_clk);
    sp_set = 1'b1;
    sp_value = sp;
    sr_set = 1'b1;
    sr_value = sr;
    @(negedge ref_clk);
    sp_set = 1'b0;
    sr_set = 1'b0;
    esp = sp;
    efl = {sr[5], sr[4], sr[3], sr[8], sr[2], sr[1], sr[0]};
  endtask

  // ==========================================================
  // One operation; read data answers each read pulse one cycle later
  task automatic run(input srx_pkg::srx_op_e op, input logic byt,
                     input logic rg, input logic [15:0] o,
                     input logic [15:0] d0, input logic [15:0] d1);
    int k;
    int nr;
    logic [19:0] ra;
    logic pend;
    pend = 1'b0;
    nr = 0;
    ra = esp;
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = op;
    op_byte = byt;
    dst_is_reg = rg;
    operand = o;
    @(negedge ref_clk);
    op_valid = 1'b0;
    saw_wr = 1'b0;
    saw_dst = 1'b0;
    lat = 0;
    for (k = 1; k <= 8 && lat == 0; k++) begin
      // Data answers one cycle after the read pulse, then goes stale
      if (pend) begin
        mem_rdata = (nr == 0) ? d0 : d1;
        nr++;
      end else begin
        mem_rdata = ~mem_rdata;
      end
      pend = 1'b0;
      if (mem_rd_q === 1'b1) begin
        check(mem_addr_q, ra, "read address");
        ra = ra + 20'h00002;
        pend = 1'b1;
      end
      if (mem_wr_q === 1'b1) begin
        saw_wr = 1'b1;
        c_maddr = mem_addr_q;
        c_mwd = mem_wdata_q;
        c_mbe = mem_be_q;
      end
      if (dst_wr_q === 1'b1) begin
        saw_dst = 1'b1;
        c_dwd = dst_wdata_q;
        c_dbe = dst_be_q;
      end
      if (done_q === 1'b1) lat = k;
      if (lat == 0) @(negedge ref_clk);
    end
    if (lat == 0) begin
      check(20'h0, 20'h1, "done timeout");
      finish_test();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_returns();
    load(20'h00400, 16'h0000);
    run(srx_pkg::OP_INTERRUPT_RETURN, 1'b0, 1'b0, 16'h0, 16'h713f, 16'h4321);
    esp = 20'h00404;
    epc = 20'h74321;
    efl = 7'h7f;
    check(20'(lat), 20'h5, "interrupt_return latency");
    check(20'({saw_wr, saw_dst}), 20'h0, "interrupt_return writes");
    chk_state("interrupt_return");
    run(srx_pkg::OP_SUBROUTINE_EXIT, 1'b0, 1'b0, 16'h0, 16'hbeef, 16'h0);
    esp = 20'h00406;
    epc = 20'h0beef;
    check(20'(lat), 20'h3, "ret latency");
    check(20'({saw_wr, saw_dst}), 20'h0, "ret writes");
    chk_state("ret");
    $display("Test returns done");
  endtask

  task automatic t_pops();
    load(20'h00800, 16'h013f);
    run(srx_pkg::OP_POP, 1'b0, 1'b1, 16'h0, 16'ha5c3, 16'h0);
    esp = 20'h00802;
    check(20'(lat), 20'h3, "pop latency");
    check(20'(c_dwd), 20'h0a5c3, "pop word data");
    check(20'(c_dbe), 20'h3, "pop word lanes");
    chk_state("pop word");
    run(srx_pkg::OP_POP, 1'b1, 1'b1, 16'h0, 16'ha5c3, 16'h0);
    esp = 20'h00804;
    check(20'(c_dwd), 20'h000c3, "pop byte reg data");
    check(20'(c_dbe), 20'h3, "pop byte reg lanes");
    chk_state("pop byte reg");
    run(srx_pkg::OP_POP, 1'b1, 1'b0, 16'h0, 16'h5a3c, 16'h0);
    esp = 20'h00806;
    check(20'(c_dwd[7:0]), 20'h0003c, "pop byte mem data");
    check(20'(c_dbe), 20'h1, "pop byte mem lanes");
    chk_state("pop byte mem");
    $display("Test pops done");
  endtask

  task automatic t_push_nop();
    load(20'h00000, 16'h0000);
    run(srx_pkg::OP_PUSH, 1'b0, 1'b0, 16'h1234, 16'h0, 16'h0);
    esp = 20'hffffe;
    check(20'(lat), 20'h1, "push latency");
    check(c_maddr, 20'hffffe, "push address");
    check(20'(c_mwd), 20'h01234, "push data");
    check(20'(c_mbe), 20'h3, "push lanes");
    chk_state("push word");
    run(srx_pkg::OP_PUSH, 1'b1, 1'b0, 16'h12ab, 16'h0, 16'h0);
    esp = 20'hffffc;
    check(c_maddr, 20'hffffc, "push byte address");
    check(20'(c_mwd[7:0]), 20'h000ab, "push byte data");
    check(20'(c_mbe), 20'h1, "push byte lanes");
    chk_state("push byte");
    load(20'h01234, 16'h0125);
    run(srx_pkg::OP_NO_OPERATION, 1'b0, 1'b1, 16'hffff, 16'h0, 16'h0);
    check(20'(lat), 20'h1, "nop latency");
    check(20'({saw_wr, saw_dst}), 20'h0, "nop writes");
    chk_state("nop");
    $display("Test push and no-operation done");
  endtask

  // Returns {c, z, n, v, result}
  function automatic logic [19:0] shf(input srx_pkg::srx_op_e op,
      input logic byt, input logic [15:0] o, input logic cin);
    logic [15:0] r;
    logic c;
    logic v;
    if (op == srx_pkg::OP_SHIFT_RIGHT_ARITH) begin
      r = byt ? {8'h00, o[7], o[7:1]} : {o[15], o[15:1]};
      c = o[0];
      v = 1'b0;
    end else begin
      r = {o[14:0], (op == srx_pkg::OP_ROTATE_LEFT_CARRY) ? cin : 1'b0};
      c = byt ? o[7] : o[15];
      v = byt ? (o[7:0] >= 8'h40 && o[7:0] < 8'hc0)
              : (o >= 16'h4000 && o < 16'hc000);
    end
    if (byt) r[15:8] = 8'h00;
    return {c, (r == 16'h0000), (byt ? r[7] : r[15]), v, r};
  endfunction

  task automatic t_shifts();
    srx_pkg::srx_op_e ops [3];
    logic [19:0] e;
    ops = '{srx_pkg::OP_SHIFT_LEFT_ARITH, srx_pkg::OP_ROTATE_LEFT_CARRY,
            srx_pkg::OP_SHIFT_RIGHT_ARITH};
    load(20'h00100, 16'h0038);
    for (int i = 0; i < 60; i++) begin
      e = shf(ops[i / 20], i[1], tv[(i / 2) % 10], efl[srx_pkg::FLG_C]);
      run(ops[i / 20], i[1], i[0], tv[(i / 2) % 10], 16'h0, 16'h0);
      check(20'(lat), 20'h1, "shift latency");
      if (i[1] && !i[0]) begin
        check(20'(c_dwd[7:0]), 20'(e[7:0]), "byte shift mem");
        check(20'(c_dbe), 20'h1, "byte shift lanes");
      end else begin
        check(20'(c_dwd), 20'(e[15:0]), "shift result");
        check(20'(c_dbe), 20'h3, "shift lanes");
      end
      if (i < 20 && !i[1]) begin
        check(20'(c_dwd), 20'(16'(tv[(i / 2) % 10] + tv[(i / 2) % 10])),
              "double");
      end
      efl[srx_pkg::FLG_C] = e[19];
      efl[srx_pkg::FLG_Z] = e[18];
      efl[srx_pkg::FLG_N] = e[17];
      efl[srx_pkg::FLG_V] = e[16];
      chk_state("shift");
    end
    $display("Test shifts done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    esp = 20'h00000;
    epc = 20'h00000;
    efl = 7'h00;
    repeat (20) @(negedge ref_clk);
    check(20'({done_q, busy_q, mem_be_q}), 20'h3, "reset outputs");
    chk_state("in reset");
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_state("after reset");
    t_returns();
    t_pops();
    t_push_nop();
    t_shifts();
    finish_test();
  end
endmodule
